// >>> soft_reset_map.vh
`ifndef SOFT_RESET_MAP_VH
`define SOFT_RESET_MAP_VH

// Register offsets from the system control base.
`define PERIPH_RST_CTRL_1_OFFSET 12'h044
`define PERIPH_RST_CTRL_2_OFFSET 12'h048
`define ADDR_WIDTH 12

// Reset values.
`define PERIPH_RST_CTRL_1_RESET 32'h00000000
`define PERIPH_RST_CTRL_2_RESET 32'h00000000

// Implemented bits of the first reset register.
`define RST1_COMPARATOR_1 25
`define RST1_COMPARATOR_0 24
`define RST1_TIMER_HI 19
`define RST1_TIMER_LO 16
`define RST1_I2C_UNIT_0 12
`define RST1_SYNC_SERIAL_0 4
`define RST1_UART_UNIT_1 1
`define RST1_UART_UNIT_0 0
`define RST1_WRITABLE_MASK 32'h030f1013

// Implemented bits of the second reset register.
`define RST2_ETH_PHY_0 30
`define RST2_ETH_MAC_0 28
`define RST2_PORT_HI 6
`define RST2_PORT_LO 0
`define RST2_WRITABLE_MASK 32'h5000007f

`endif

// >>> masked_reset_reg.v
`timescale 1ns/1ps
// One reset control register: writable bits gated by a fixed field mask and a capability mask.
module masked_reset_reg #(
	parameter [31:0] FIELD_MASK = 32'hffffffff,
	parameter [31:0] RESET_VALUE = 32'h00000000
) (
	// Clock and reset
	input wire clk_sys,
	input wire resetn,
	// Write side
	input wire wr_en,
	input wire [31:0] wr_data,
	input wire [31:0] capability,
	// State
	output reg [31:0] value_reg
);
	wire [31:0] allowed;
	wire [31:0] value_next;

	assign allowed = FIELD_MASK & capability;
	assign value_next = wr_en ? (wr_data & allowed) : (value_reg & allowed);

	always @(posedge clk_sys) begin
		if (!resetn) begin
			value_reg <= RESET_VALUE;
		end else begin
			value_reg <= value_next;
		end
	end
endmodule // masked_reset_reg

// >>> reset_line_driver.v
`timescale 1ns/1ps
// Registers each control bit onto a peripheral reset line so outputs come from flip-flops.
module reset_line_driver #(
	parameter WIDTH = 32
) (
	// Clock and reset
	input wire clk_sys,
	input wire resetn,
	// Control bits and lines
	input wire [WIDTH-1:0] ctrl,
	output reg [WIDTH-1:0] line_reg
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_line
			always @(posedge clk_sys) begin
				if (!resetn) begin
					line_reg[i] <= 1'b0;
				end else begin
					line_reg[i] <= ctrl[i];
				end
			end
		end
	endgenerate
endmodule // reset_line_driver

// >>> peripheral_soft_reset_ctrl.v
`timescale 1ns/1ps
`include "soft_reset_map.vh"
// Notes on behaviour
// [RL1] First reset register at 0x044, read/write, resets to zero.
// [RL2] Writes to first register are masked by capability register 2.
// [RL3] Second reset register at 0x048, read/write, resets to zero.
// [RL4] Writes to second register are masked by capability register 4.
// [RL5] First register bits 25 and 24 reset comparators 1 and 0.
// [RL6] First register bits 19 to 16 reset timers 3 to 0.
// [RL7] First register bit 12 resets I2C unit 0.
// [RL8] First register bit 4 resets synchronous serial unit 0.
// [RL9] First register bits 1 and 0 reset UART units 1 and 0.
// [RL10] Second register bit 30 resets Ethernet PHY unit 0.
// [RL11] Second register bit 28 resets Ethernet MAC unit 0.
// [RL12] Second register bits 6 to 0 reset GPIO ports G to A.
// [RL13] Software should preserve reserved bits and not rely on them.
// [RL14] A set bit holds its peripheral in reset; clearing releases it.
// [RL15] Bits of absent peripherals ignore writes and read as zero.
module peripheral_soft_reset_ctrl (
	// Clock and reset
	input wire clk_sys,
	input wire resetn,
	// Register port
	input wire [11:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Capability masks
	input wire [31:0] capability_reg_2,
	input wire [31:0] capability_reg_4,
	// Peripheral resets, active high
	output wire comparator_1_reset,
	output wire comparator_0_reset,
	output wire timer_3_reset,
	output wire timer_2_reset,
	output wire timer_1_reset,
	output wire timer_0_reset,
	output wire i2c_unit_0_reset,
	output wire sync_serial_0_reset,
	output wire uart_unit_1_reset,
	output wire uart_unit_0_reset,
	output wire eth_phy_0_reset,
	output wire eth_mac_0_reset,
	output wire port_g_reset,
	output wire port_f_reset,
	output wire port_e_reset,
	output wire port_d_reset,
	output wire port_c_reset,
	output wire port_b_reset,
	output wire port_a_reset
);
	wire sel_1;
	wire sel_2;
	wire [31:0] peripheral_reset_ctrl_1;
	wire [31:0] peripheral_reset_ctrl_2;
	wire [31:0] lines_1;
	wire [31:0] lines_2;
	reg [31:0] rdata_next;

	assign sel_1 = (reg_addr == `PERIPH_RST_CTRL_1_OFFSET); // [RL1]
	assign sel_2 = (reg_addr == `PERIPH_RST_CTRL_2_OFFSET); // [RL3]

	// A bit whose capability drops later is cleared at the next edge too, and its reset line releases the missing unit one edge after that.
	masked_reset_reg #(
		.FIELD_MASK(`RST1_WRITABLE_MASK),
		.RESET_VALUE(`PERIPH_RST_CTRL_1_RESET)
	) u_ctrl_1 (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.wr_en(reg_wr & sel_1),
		.wr_data(reg_wdata),
		.capability(capability_reg_2), // [RL2] [RL15]
		.value_reg(peripheral_reset_ctrl_1)
	);

	masked_reset_reg #(
		.FIELD_MASK(`RST2_WRITABLE_MASK),
		.RESET_VALUE(`PERIPH_RST_CTRL_2_RESET)
	) u_ctrl_2 (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.wr_en(reg_wr & sel_2),
		.wr_data(reg_wdata),
		.capability(capability_reg_4), // [RL4] [RL15]
		.value_reg(peripheral_reset_ctrl_2)
	);

	reset_line_driver #(.WIDTH(32)) u_lines_1 (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.ctrl(peripheral_reset_ctrl_1), // [RL14]
		.line_reg(lines_1)
	);

	reset_line_driver #(.WIDTH(32)) u_lines_2 (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.ctrl(peripheral_reset_ctrl_2), // [RL14]
		.line_reg(lines_2)
	);

	assign comparator_1_reset = lines_1[`RST1_COMPARATOR_1]; // [RL5]
	assign comparator_0_reset = lines_1[`RST1_COMPARATOR_0]; // [RL5]
	assign timer_3_reset = lines_1[`RST1_TIMER_HI]; // [RL6]
	assign timer_2_reset = lines_1[`RST1_TIMER_LO + 2]; // [RL6]
	assign timer_1_reset = lines_1[`RST1_TIMER_LO + 1]; // [RL6]
	assign timer_0_reset = lines_1[`RST1_TIMER_LO]; // [RL6]
	assign i2c_unit_0_reset = lines_1[`RST1_I2C_UNIT_0]; // [RL7]
	assign sync_serial_0_reset = lines_1[`RST1_SYNC_SERIAL_0]; // [RL8]
	assign uart_unit_1_reset = lines_1[`RST1_UART_UNIT_1]; // [RL9]
	assign uart_unit_0_reset = lines_1[`RST1_UART_UNIT_0]; // [RL9]
	assign eth_phy_0_reset = lines_2[`RST2_ETH_PHY_0]; // [RL10]
	assign eth_mac_0_reset = lines_2[`RST2_ETH_MAC_0]; // [RL11]
	assign port_g_reset = lines_2[`RST2_PORT_HI]; // [RL12]
	assign port_f_reset = lines_2[`RST2_PORT_LO + 5]; // [RL12]
	assign port_e_reset = lines_2[`RST2_PORT_LO + 4]; // [RL12]
	assign port_d_reset = lines_2[`RST2_PORT_LO + 3]; // [RL12]
	assign port_c_reset = lines_2[`RST2_PORT_LO + 2]; // [RL12]
	assign port_b_reset = lines_2[`RST2_PORT_LO + 1]; // [RL12]
	assign port_a_reset = lines_2[`RST2_PORT_LO]; // [RL12]

	// Reserved bits and unmapped addresses read as zero.
	always @* begin
		rdata_next = 32'h00000000;
		if (reg_rd && sel_1) begin
			rdata_next = peripheral_reset_ctrl_1; // [RL1] [RL13]
		end else if (reg_rd && sel_2) begin
			rdata_next = peripheral_reset_ctrl_2; // [RL3] [RL13]
		end
	end

	always @(posedge clk_sys) begin
		if (!resetn) begin
			reg_rdata <= 32'h00000000;
		end else begin
			reg_rdata <= rdata_next;
		end
	end
endmodule // peripheral_soft_reset_ctrl

// >>> peripheral_soft_reset_ctrl_properties.sv
`timescale 1ns/1ps
module peripheral_soft_reset_ctrl_properties (
	input wire clk_sys, resetn, reg_wr, reg_rd, comparator_1_reset, port_a_reset, eth_mac_0_reset,
	input wire [11:0] reg_addr,
	input wire [31:0] reg_wdata, reg_rdata, capability_reg_2, capability_reg_4
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata not zero");
	a_rd_unmapped: assert property ($past(reg_rd) && $past(reg_addr) != 12'h044 &&
		$past(reg_addr) != 12'h048 |-> reg_rdata == 32'h0) else $error("unmapped read");
	// Read data show the register as masked at the edge before the read, so a capability drop lags one cycle.
	a_rd1_mask: assert property ($past(reg_rd && reg_addr == 12'h044) |->
		(reg_rdata & ~(32'h030f1013 & $past(capability_reg_2, 2))) == 32'h0) else $error("reg1 mask");
	a_rd2_mask: assert property ($past(reg_rd && reg_addr == 12'h048) |->
		(reg_rdata & ~(32'h5000007f & $past(capability_reg_4, 2))) == 32'h0) else $error("reg2 mask");
	a_wr_then_rd: assert property (reg_wr && reg_addr == 12'h044 ##1 reg_rd && reg_addr == 12'h044 &&
		$stable(capability_reg_2) |=> reg_rdata == ($past(reg_wdata, 2) & 32'h030f1013 & $past(capability_reg_2)))
		else $error("read after write");
	a_comparator_1_reset_rise: assert property ($rose(comparator_1_reset) |->
		$past(reg_wr && reg_addr == 12'h044 && reg_wdata[25] && capability_reg_2[25], 2)) else $error("comparator_1_reset line");
	a_porta_rise: assert property ($rose(port_a_reset) |->
		$past(reg_wr && reg_addr == 12'h048 && reg_wdata[0] && capability_reg_4[0], 2)) else $error("port a line");
	a_mac_rise: assert property ($rose(eth_mac_0_reset) |->
		$past(reg_wr && reg_addr == 12'h048 && reg_wdata[28] && capability_reg_4[28], 2)) else $error("mac line");
endmodule // peripheral_soft_reset_ctrl_properties

// >>> peripheral_soft_reset_ctrl_bench.sv
`timescale 1ns/1ps
module peripheral_soft_reset_ctrl_bench;
	reg clk_sys = 1'b0;
	reg resetn = 1'b0;
	reg [11:0] reg_addr = 12'h000;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [31:0] capability_reg_2 = 32'hffffffff;
	reg [31:0] capability_reg_4 = 32'hffffffff;
	wire [31:0] reg_rdata;
	wire [18:0] ln;
	integer bad_count = 0;
	integer num_checks = 0;
	integer i, k;
	reg [31:0] v;
	always #20 clk_sys = ~clk_sys;
	peripheral_soft_reset_ctrl dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.capability_reg_2, .capability_reg_4, .comparator_1_reset(ln[18]), .comparator_0_reset(ln[17]),
		.timer_3_reset(ln[16]), .timer_2_reset(ln[15]), .timer_1_reset(ln[14]), .timer_0_reset(ln[13]),
		.i2c_unit_0_reset(ln[12]), .sync_serial_0_reset(ln[11]), .uart_unit_1_reset(ln[10]),
		.uart_unit_0_reset(ln[9]), .eth_phy_0_reset(ln[8]), .eth_mac_0_reset(ln[7]), .port_g_reset(ln[6]),
		.port_f_reset(ln[5]), .port_e_reset(ln[4]), .port_d_reset(ln[3]), .port_c_reset(ln[2]),
		.port_b_reset(ln[1]), .port_a_reset(ln[0]));
	// Expected reset lines, in the packing order of ln.
	function [31:0] lx(input [31:0] a, input [31:0] b);
		lx = {13'h0, a[25:24], a[19:16], a[12], a[4], a[1:0], b[30], b[28], b[6:0]};
	endfunction
	task chk(input [31:0] s, input [31:0] e);
		begin
			num_checks = num_checks + 1;
			if (s !== e) begin
				bad_count = bad_count + 1;
				$display("ERROR %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		begin
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
		end
	endtask
	// Read data is looked at mid-cycle, so the edge that updates it has settled.
	task rd(input [11:0] a, input [31:0] e);
		begin
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			@(negedge clk_sys) chk(reg_rdata, e);
			@(posedge clk_sys);
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d errors %0d", num_checks, bad_count);
			if (bad_count == 0 && num_checks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	initial begin
		#100000;
		bad_count = bad_count + 1;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(12'h044, 32'h0);
		rd(12'h048, 32'h0);
		// Walking one bit per pass shows each line on its own pin; the second pass thins the capabilities.
		for (k = 0; k < 2; k = k + 1) begin
			capability_reg_2 <= k ? 32'haaaaaaaa : 32'hffffffff;
			capability_reg_4 <= k ? 32'h55555555 : 32'hffffffff;
			for (i = 0; i < 32; i = i + 1) begin
				v = 32'h1 << i;
				wr(12'h044, v);
				rd(12'h044, v & 32'h030f1013 & capability_reg_2);
				wr(12'h048, v);
				rd(12'h048, v & 32'h5000007f & capability_reg_4);
				@(negedge clk_sys) chk({13'h0, ln}, lx(v & capability_reg_2, v & capability_reg_4));
				@(posedge clk_sys);
			end
		end
		wr(12'h044, 32'hffffffff);
		rd(12'h040, 32'h0);
		wr(12'h040, 32'h0);
		rd(12'h044, 32'h030f1013 & capability_reg_2);
		// Software read-modify-write: one unit is released and the reserved bits go back as they were read.
		v = 32'h030f1013 & capability_reg_2 & ~32'h02000000;
		wr(12'h044, v);
		rd(12'h044, v);
		wr(12'h048, 32'hffffffff);
		rd(12'h048, 32'h5000007f & capability_reg_4);
		@(negedge clk_sys) chk({13'h0, ln}, lx(v, capability_reg_4));
		@(posedge clk_sys);
		// A reset in mid-run must clear both registers and every line, not only the power-up state.
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(12'h044, 32'h0);
		rd(12'h048, 32'h0);
		@(negedge clk_sys) chk({13'h0, ln}, 32'h0);
		@(posedge clk_sys);
		wr(12'h044, 32'hffffffff);
		capability_reg_2 <= 32'h0;
		@(posedge clk_sys);
		rd(12'h044, 32'h0);
		@(negedge clk_sys) chk({13'h0, ln}, 32'h0);
		complete_run;
	end
endmodule // peripheral_soft_reset_ctrl_bench
bind peripheral_soft_reset_ctrl peripheral_soft_reset_ctrl_properties chk_i (.*);
